// ### inc/ssx_pkg.sv
// ssx_pkg: constants and types of the synchronous serial transfer engine.
// assumes a 100 MHz system clock and a 32-bit classic wishbone master.
package ssx_pkg;

	// register byte addresses
	localparam logic [7:0] SSX_ADR_CTRL = 8'h00;
	localparam logic [7:0] SSX_ADR_STAT = 8'h04;
	localparam logic [7:0] SSX_ADR_TXB  = 8'h08;
	localparam logic [7:0] SSX_ADR_RXB  = 8'h0C;

	// control word positions
	localparam int SSX_CTRL_MODE_LSB = 0;
	localparam int SSX_CTRL_DIR_BIT  = 2;
	localparam int SSX_CTRL_SCK_LSB  = 3;
	localparam int SSX_CTRL_START    = 6;
	localparam int SSX_CTRL_ABORT    = 7;

	localparam logic [1:0] SSX_MODE_TX  = 2'h0;
	localparam logic [1:0] SSX_MODE_RX  = 2'h1;
	localparam logic [1:0] SSX_MODE_TRX = 2'h2;
	localparam logic [2:0] SSX_SCK_EXT  = 3'h7;
	localparam logic [2:0] SSX_LAST_BIT = 3'h7;

	typedef struct packed {
		logic       start;
		logic [2:0] sck;
		logic       dir;
		logic [1:0] mode;
	} ssx_ctrl_t;

	typedef struct packed {
		logic ovr;
		logic udr;
		logic shf;
		logic act;
		logic rx_buffer_full_flag;
		logic txe;
	} ssx_stat_t;

	localparam ssx_ctrl_t SSX_CTRL_RST = 7'h00;
	localparam ssx_stat_t SSX_STAT_RST = 6'h01;

	// half serial period minus one, in system cycles, per clock select
	localparam logic [11:0] SSX_HALF_TAB [0:6] = '{
		12'h7FF, 12'h07F, 12'h03F, 12'h01F, 12'h00F, 12'h007, 12'h003
	};

	typedef enum logic [2:0] {
		SSX_IDLE  = 3'b001,
		SSX_ARM   = 3'b010,
		SSX_SHIFT = 3'b100
	} ssx_state_t;

endpackage

// ### design/ssx_engine.sv
// ssx_engine: eight-bit synchronous serial transfer engine, wishbone slave.
// assumes one 100 MHz clock; external serial clock is sampled and synced.
`timescale 1ns/1ps
`default_nettype none
module ssx_engine
	import ssx_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        serial_clock_pin_i,
	output logic             serial_clock_pin_o,
	output logic             serial_clock_pin_oe_n_o,
	output logic             serial_out_pin_o,
	input  wire logic        serial_in_pin_i,
	output logic             serial_irq_o
);

	ssx_ctrl_t  ctrl_q;
	ssx_stat_t  stat_q;
	ssx_state_t st_q;
	logic [7:0]  txb_q;
	logic [7:0]  rxb_q;
	logic [7:0]  tx_sh_q;
	logic [7:0]  rx_sh_q;
	logic [2:0]  cnt_q;
	logic [11:0] div_q;
	logic        sck_q;
	logic        so_q;
	logic        loaded_q;
	logic        pend_q;
	logic        irq_q;
	logic        ack_q;
	logic [31:0] dat_q;
	logic        s1_q;
	logic        s2_q;
	logic        s3_q;

	// bus decode
	wire req     = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr      = req & wb_we_i & wb_sel_i[0];
	wire rd      = req & ~wb_we_i;
	wire wr_ctrl = wr & (wb_adr_i == SSX_ADR_CTRL);
	wire wr_tx   = wr & (wb_adr_i == SSX_ADR_TXB);
	wire rd_rx   = rd & (wb_adr_i == SSX_ADR_RXB);
	wire abort   = wr_ctrl & wb_dat_i[SSX_CTRL_ABORT];
	wire clr     = rst_i | abort;

	wire tx_en = (ctrl_q.mode == SSX_MODE_TX) |
		(ctrl_q.mode == SSX_MODE_TRX);
	wire rx_en = (ctrl_q.mode == SSX_MODE_RX) |
		(ctrl_q.mode == SSX_MODE_TRX);
	wire ext   = ctrl_q.sck == SSX_SCK_EXT;
	wire dir   = ctrl_q.dir;
	wire idle  = st_q == SSX_IDLE;
	wire arm   = st_q == SSX_ARM;
	wire shift = st_q == SSX_SHIFT;

	// no internal start without tx data when sending, nor with a full rx buffer when receiving
	wire arm_ok = ctrl_q.start & ~(tx_en & stat_q.txe) &
		~(rx_en & stat_q.rx_buffer_full_flag);
	wire run  = ~ext & (shift | (arm & arm_ok));
	wire [11:0] half = (ctrl_q.sck == SSX_SCK_EXT) ? 12'h000 :
		SSX_HALF_TAB[ctrl_q.sck];
	wire tick = div_q == half;

	// edges only from the second sync stage on
	wire fall_ev = ext ? (s3_q & ~s2_q) : (run & tick & sck_q);
	wire rise_ev = ext ? (~s3_q & s2_q) : (run & tick & ~sck_q);

	wire begin_ev  = arm & fall_ev & ctrl_q.start;
	wire byte_done = shift & rise_ev & (cnt_q == SSX_LAST_BIT);
	wire load_ev   = begin_ev & tx_en & ~stat_q.txe & ~stat_q.udr;
	// shift begins with nothing to send
	wire udr_set   = begin_ev & tx_en & stat_q.txe;
	// empty set at the rise after a load
	wire txe_set   = shift & rise_ev & (cnt_q == 3'h0) & loaded_q;
	wire rx_take   = byte_done & rx_en & ~stat_q.ovr;
	// a read in the same cycle still frees the buffer
	wire ovr_set   = rx_take & stat_q.rx_buffer_full_flag & ~rd_rx;
	wire rxf_set   = rx_take & ~ovr_set;
	wire act_clr   = (arm & ~ctrl_q.start) |
		(byte_done & ~ctrl_q.start);

	wire [7:0] tx_nx = dir ? {1'b0, tx_sh_q[7:1]} :
		{tx_sh_q[6:0], 1'b0};
	wire tx_bit_ld = dir ? txb_q[0] : txb_q[7];
	wire tx_bit_nx = dir ? tx_nx[0] : tx_nx[7];
	wire [7:0] rx_nx = dir ? {serial_in_pin_i, rx_sh_q[7:1]} :
		{rx_sh_q[6:0], serial_in_pin_i};

	wire [7:0] rd_mux =
		(wb_adr_i == SSX_ADR_CTRL) ? {1'b0, ctrl_q} :
		(wb_adr_i == SSX_ADR_STAT) ? {2'b00, stat_q} :
		(wb_adr_i == SSX_ADR_TXB)  ? txb_q :
		(wb_adr_i == SSX_ADR_RXB)  ? rxb_q : 8'h00;

	// wishbone answer, one wait state, unmapped reads as zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (rd)
				dat_q <= {24'h00_0000, rd_mux};
		end
	end

	// control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= SSX_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= wb_dat_i[6:0];
			if (abort)
				ctrl_q.start <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else begin
			s1_q <= serial_clock_pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// divider restarts, so first fall comes a full half period (half plus one cycles) after run begins
	always_ff @(posedge clk_i) begin
		if (clr | ~run | tick)
			div_q <= 12'h000;
		else
			div_q <= div_q + 12'h001;
	end

	always_ff @(posedge clk_i) begin
		if (clr | ~run)
			sck_q <= 1'b1;
		else if (tick)
			sck_q <= ~sck_q;
	end

	// sequencer
	always_ff @(posedge clk_i) begin
		if (clr) begin
			st_q  <= SSX_IDLE;
			cnt_q <= 3'h0;
		end else begin
			case (st_q)
				SSX_IDLE: begin
					if (ctrl_q.start)
						st_q <= SSX_ARM;
				end
				SSX_ARM: begin
					if (~ctrl_q.start) begin
						st_q <= SSX_IDLE;
					end else if (fall_ev) begin
						st_q  <= SSX_SHIFT;
						cnt_q <= 3'h0;
					end
				end
				SSX_SHIFT: begin
					// stop only at a byte end
					if (byte_done)
						st_q <= ctrl_q.start ? SSX_ARM : SSX_IDLE;
					if (rise_ev)
						cnt_q <= cnt_q + 3'h1;
				end
				default: st_q <= SSX_IDLE;
			endcase
		end
	end

	// buffers; write data lands even mid-byte
	always_ff @(posedge clk_i) begin
		if (clr) begin
			txb_q <= 8'h00;
			rxb_q <= 8'h00;
		end else begin
			// a timely write is picked up next fall
			if (wr_tx)
				txb_q <= wb_dat_i[7:0];
			if (rxf_set)
				rxb_q <= rx_nx;
		end
	end

	// transmit path
	always_ff @(posedge clk_i) begin
		if (clr) begin
			tx_sh_q  <= 8'h00;
			so_q     <= 1'b1;
			loaded_q <= 1'b0;
		end else if (udr_set | stat_q.udr) begin
			so_q     <= 1'b1;
			loaded_q <= 1'b0;
		end else if (load_ev) begin
			tx_sh_q  <= txb_q;
			so_q     <= tx_bit_ld;
			loaded_q <= 1'b1;
		end else if (shift & fall_ev & loaded_q) begin
			// next bit on each falling edge
			tx_sh_q <= tx_nx;
			so_q    <= tx_bit_nx;
		end else if (act_clr) begin
			// output high once stopped; an internal-clock stall keeps the last bit
			so_q     <= 1'b1;
			loaded_q <= 1'b0;
		end
	end

	// sample on rising edges, frozen on overrun
	always_ff @(posedge clk_i) begin
		if (clr)
			rx_sh_q <= 8'h00;
		else if (shift & rise_ev & rx_en & ~stat_q.ovr)
			rx_sh_q <= rx_nx;
	end

	// status flags; hardware set wins over a clear
	always_ff @(posedge clk_i) begin
		if (clr) begin
			stat_q <= SSX_STAT_RST;
		end else begin
			if (txe_set)
				stat_q.txe <= 1'b1;
			else if (wr_tx)
				stat_q.txe <= 1'b0;
			if (rxf_set)
				stat_q.rx_buffer_full_flag <= 1'b1;
			else if (rd_rx)
				stat_q.rx_buffer_full_flag <= 1'b0;
			// active at the first falling edge
			if (begin_ev)
				stat_q.act <= 1'b1;
			else if (act_clr)
				stat_q.act <= 1'b0;
			if (begin_ev)
				stat_q.shf <= 1'b1;
			else if (byte_done)
				stat_q.shf <= 1'b0;
			if (udr_set)
				stat_q.udr <= 1'b1;
			if (ovr_set)
				stat_q.ovr <= 1'b1;
		end
	end

	// tx events fire on the following fall
	always_ff @(posedge clk_i) begin
		if (clr) begin
			pend_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			if (txe_set | udr_set)
				pend_q <= 1'b1;
			else if (fall_ev)
				pend_q <= 1'b0;
			// rx byte or overrun raises irq now
			irq_q <= rxf_set | ovr_set | (pend_q & fall_ev);
		end
	end

	assign wb_ack_o                = ack_q;
	assign wb_dat_o                = dat_q;
	assign serial_clock_pin_o      = sck_q;
	// drive the pin low-active enable only for internal clock
	assign serial_clock_pin_oe_n_o = ext;
	assign serial_out_pin_o        = so_q;
	assign serial_irq_o            = irq_q;

endmodule
`default_nettype wire

// ### verif/ssx_props.sv
// ssx_props: port checks of ssx_engine.
// bound to the engine; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ssx_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        serial_clock_pin_o,
	input wire logic        serial_clock_pin_oe_n_o,
	input wire logic        serial_out_pin_o,
	input wire logic        serial_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("ack missing");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_cause_a: assert property ($rose(wb_ack_o)
		|-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
	dat_zero_a: assert property (wb_ack_o
		|-> wb_dat_o[31:8] == 24'h000000) else $error("upper data set");
	irq_pulse_a: assert property (serial_irq_o |=> !serial_irq_o)
		else $error("irq too long");
	idle_rst_a: assert property ($fell(rst_i) |->
		serial_clock_pin_o && serial_out_pin_o) else $error("not idle");
	sck_high_a: assert property ($rose(serial_clock_pin_o)
		|-> serial_clock_pin_o [*4]) else $error("sck high short");
	so_fall_a: assert property ($fell(serial_out_pin_o)
		&& !serial_clock_pin_oe_n_o |-> $fell(serial_clock_pin_o))
		else $error("so off edge");
	cover property ($fell(serial_clock_pin_o));
	cover property (serial_irq_o);
	cover property (wb_ack_o && wb_dat_o[7:0] != 8'h00);
endmodule
bind ssx_engine ssx_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o), .serial_clock_pin_o(serial_clock_pin_o),
	.serial_clock_pin_oe_n_o(serial_clock_pin_oe_n_o),
	.serial_out_pin_o(serial_out_pin_o), .serial_irq_o(serial_irq_o));
`default_nettype wire

// ### verif/ssx_peer.sv
// ssx_peer: serial peer, sends a byte msb first, records output bits.
// assumes the clock wire idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module ssx_peer (
	input  wire logic       sck_i,
	input  wire logic       so_i,
	input  wire logic [7:0] tx_i,
	output logic            si_o,
	output logic [15:0]     got_o,
	output int              nbit_o
);
	int k = 0;
	initial begin
		si_o = 1'b1;
		got_o = 16'h0000;
		nbit_o = 0;
	end
	always @(negedge sck_i) begin
		si_o <= tx_i[7 - k];
		k <= (k + 1) % 8;
	end
	always @(posedge sck_i) begin
		got_o <= {got_o[14:0], so_i};
		nbit_o <= nbit_o + 1;
	end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// testbench: wishbone-driven checks of ssx_engine with a serial peer.
// assumes internal clock select 6, a four-cycle half period,
// and an external master that idles the released clock pin high.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
	num_errors++; $display("wrong value at %0t: %h vs %h", $time, \
	(a), (e)); end end
module testbench;
	import ssx_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ext_sck = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dw = 32'h00000000;
	logic [31:0] dr;
	logic        ack, sck, oe_n, so, irq, si;
	wire logic   sck_w;
	logic [7:0]  ptx = 8'h00;
	logic [15:0] got;
	int          nbit, irqs = 0, num_errors = 0, n_compared = 0;
	// released pin: bench plays the external clock master
	assign sck_w = oe_n ? ext_sck : sck;
	always #5 clk = ~clk;
	always @(posedge clk) if (irq === 1'b1) irqs++;
	ssx_engine dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck),
		.serial_clock_pin_oe_n_o(oe_n), .serial_out_pin_o(so),
		.serial_in_pin_i(si), .serial_irq_o(irq));
	ssx_peer peer (.sck_i(sck_w), .so_i(so), .tx_i(ptx), .si_o(si),
		.got_o(got), .nbit_o(nbit));
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] r);
		int t;
		t = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= {24'h000000, d};
		do @(posedge clk); while (ack !== 1'b1 && ++t < 50);
		if (ack !== 1'b1) num_errors++;
		r = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		wb(1'b0, a, 8'h00, r);
	endtask
	task automatic poll(input int b, output logic [31:0] r);
		int t;
		t = 0;
		do rd(SSX_ADR_STAT, r); while (r[b] !== 1'b1 && ++t < 200);
		if (r[b] !== 1'b1) num_errors++;
	endtask
	// external clock, 8 cycles low and high, idle high after
	task automatic ext_clk(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (8) @(posedge clk);
			ext_sck <= 1'b0;
			repeat (8) @(posedge clk);
			ext_sck <= 1'b1;
		end
		repeat (8) @(posedge clk);
	endtask
	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
	endfunction
	task automatic test_reset;
		logic [31:0] r;
		rd(SSX_ADR_STAT, r);
		`CHK(r, 32'h01)
		rd(8'h10, r);
		`CHK(r, 32'h00)
		`CHK(sck, 1'b1)
		`CHK(oe_n, 1'b0)
		$display("test_reset done");
	endtask
	task automatic test_tx(input logic d);
		logic [31:0] r;
		int b, i0;
		wr(SSX_ADR_CTRL, {2'b10, 3'h6, d, SSX_MODE_TX});
		b = nbit;
		i0 = irqs;
		wr(SSX_ADR_TXB, 8'hC1);
		rd(SSX_ADR_STAT, r);
		`CHK(r, 32'h00)
		wr(SSX_ADR_CTRL, {2'b01, 3'h6, d, SSX_MODE_TX});
		poll(0, r);
		`CHK(r[3:2], 2'b11)
		wr(SSX_ADR_TXB, 8'h1E);
		for (int t = 0; t < 400 && nbit < b + 16; t++) @(posedge clk);
		`CHK(got, d ? {rev(8'hC1), rev(8'h1E)} : 16'hC11E)
		repeat (40) @(posedge clk);
		`CHK(sck, 1'b1)
		`CHK(nbit - b, 16)
		`CHK(irqs - i0, 2)
		wr(SSX_ADR_CTRL, {2'b00, 3'h6, d, SSX_MODE_TX});
		rd(SSX_ADR_STAT, r);
		`CHK(r, 32'h01)
		`CHK(so, 1'b1)
		$display("test_tx dir %0d done", d);
	endtask
	task automatic test_rx;
		logic [31:0] r;
		int i0;
		wr(SSX_ADR_CTRL, {2'b10, 3'h6, 1'b0, SSX_MODE_RX});
		ptx <= 8'h96;
		i0 = irqs;
		wr(SSX_ADR_CTRL, {2'b01, 3'h6, 1'b0, SSX_MODE_RX});
		poll(1, r);
		repeat (40) @(posedge clk);
		`CHK(sck, 1'b1)
		ptx <= 8'h5A;
		rd(SSX_ADR_RXB, r);
		`CHK(r, 32'h96)
		rd(SSX_ADR_STAT, r);
		`CHK(r[1], 1'b0)
		poll(1, r);
		rd(SSX_ADR_RXB, r);
		`CHK(r, 32'h5A)
		`CHK(irqs - i0, 2)
		wr(SSX_ADR_CTRL, {2'b11, 3'h6, 1'b0, SSX_MODE_RX});
		rd(SSX_ADR_CTRL, r);
		`CHK(r, 32'h31)
		rd(SSX_ADR_STAT, r);
		`CHK(r, 32'h01)
		`CHK(sck, 1'b1)
		$display("test_rx done");
	endtask
	task automatic test_trx;
		logic [31:0] r;
		int i0;
		wr(SSX_ADR_CTRL, {2'b10, 3'h6, 1'b0, SSX_MODE_TRX});
		ptx <= 8'h69;
		i0 = irqs;
		wr(SSX_ADR_TXB, 8'h96);
		wr(SSX_ADR_CTRL, {2'b01, 3'h6, 1'b0, SSX_MODE_TRX});
		poll(1, r);
		rd(SSX_ADR_RXB, r);
		`CHK(r, 32'h69)
		`CHK(got[7:0], 8'h96)
		`CHK(irqs - i0, 2)
		wr(SSX_ADR_CTRL, {2'b10, 3'h6, 1'b0, SSX_MODE_TRX});
		$display("test_trx done");
	endtask
	task automatic test_ext_tx;
		logic [31:0] r;
		int i0;
		wr(SSX_ADR_CTRL, {2'b10, 3'h7, 1'b0, SSX_MODE_TX});
		i0 = irqs;
		wr(SSX_ADR_TXB, 8'hA5);
		wr(SSX_ADR_CTRL, {2'b01, 3'h7, 1'b0, SSX_MODE_TX});
		`CHK(oe_n, 1'b1)
		ext_clk(2);
		wr(SSX_ADR_TXB, 8'h5A);
		ext_clk(6);
		`CHK(got[7:0], 8'hA5)
		ext_clk(8);
		`CHK(got[7:0], 8'h5A)
		ext_clk(8);
		`CHK(got[7:0], 8'hFF)
		rd(SSX_ADR_STAT, r);
		`CHK(r, 32'h15)
		`CHK(irqs - i0, 3)
		wr(SSX_ADR_CTRL, {2'b00, 3'h7, 1'b0, SSX_MODE_TX});
		rd(SSX_ADR_STAT, r);
		`CHK(r, 32'h11)
		wr(SSX_ADR_CTRL, {2'b10, 3'h7, 1'b0, SSX_MODE_TX});
		rd(SSX_ADR_STAT, r);
		`CHK(r, 32'h01)
		$display("test_ext_tx done");
	endtask
	task automatic test_ext_rx;
		logic [31:0] r;
		int i0;
		wr(SSX_ADR_CTRL, {2'b10, 3'h7, 1'b0, SSX_MODE_RX});
		ptx <= 8'h3C;
		i0 = irqs;
		wr(SSX_ADR_CTRL, {2'b01, 3'h7, 1'b0, SSX_MODE_RX});
		ext_clk(8);
		rd(SSX_ADR_STAT, r);
		`CHK(r, 32'h07)
		ptx <= 8'hC3;
		ext_clk(8);
		wr(SSX_ADR_CTRL, {2'b00, 3'h7, 1'b0, SSX_MODE_RX});
		rd(SSX_ADR_RXB, r);
		`CHK(r, 32'h3C)
		rd(SSX_ADR_STAT, r);
		`CHK(r, 32'h21)
		`CHK(irqs - i0, 2)
		wr(SSX_ADR_CTRL, {2'b10, 3'h6, 1'b0, SSX_MODE_RX});
		$display("test_ext_rx done");
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		test_reset;
		test_tx(1'b0);
		test_tx(1'b1);
		test_rx;
		test_trx;
		test_ext_tx;
		test_ext_rx;
		tally_and_finish;
	end
	// whole run needs under two thousand cycles
	initial begin
		#400000;
		num_errors++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
